/* src/mks_regs.svh */
// Register offsets, field positions, reset values and timing counts of the keypad scanner.
// Assumes a 100 MHz pclk and a byte-addressed APB register window.
`ifndef MKS_REGS_SVH
`define MKS_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define MKS_OFF_RESULT 8'h00
`define MKS_OFF_CTRL 8'h04
`define MKS_OFF_STATUS 8'h08

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define MKS_RES_PEND_BIT 15
`define MKS_CTRL_EN_BIT 0
`define MKS_CTRL_RESET 1'h1
`define MKS_REF_RESET 8'hff
`define MKS_STATUS_BUSY_BIT 16
`define MKS_LOCK_BASE 6'h3d
`define MKS_SHOT_BASE 6'h38

// ----------------------------------------
// Timing
// ----------------------------------------
`define MKS_CLK_MHZ 100
`define MKS_SETTLE_TIME_US 5000
`define MKS_SETTLE_CYCLES (`MKS_SETTLE_TIME_US * `MKS_CLK_MHZ)
`define MKS_PIN_WAIT 20'h00008

`endif

/* src/mks_pkg.sv */
// Types shared by the keypad scanner.
// Assumes nothing of its surroundings.
package mks_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_SETTLE, ST_COL_SAMP, ST_ROW_WAIT, ST_ROW_SAMP, ST_PROCESS, ST_RECOVER
	} mks_state_t;
endpackage : mks_pkg

/* src/mks_scanner.sv */
// Matrix keypad scanner: 8 x 8 push-button matrix to a 0-63 scancode, with APB registers.
// Assumes external pull-ups on rows and columns, the pin wire resolved from the enables outside,
// and one APB master on pclk.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "mks_regs.svh"

// What this block does
// - Rows low read columns, then columns low read rows.
// - Scancode 0-63 from position, 8 x 8 matrix only.
// - All rows driven low before idle wait.
// - Release wakes scan but yields no code.
// - One event per press, no auto repeat.
// - Wait settling delay after column change.
// - Several keys: report top-left only.
// - Driving lines low, sensing lines pulled high.
// - Three lock keys toggle secondary-mode flags.
// - Four one-shot keys affect next key only.
// - Alternation keys also deliver ordinary scancode.
// - Result: code bits 5:0, pending bit 15.
// - Scanner sets pending, consumer clears it.
// - Reset clears flags, result and pending.
// - After processing, rows low, back to idle.
// - Code: column index low, row index high.
// - Non-alternation key clears one-shots, sets pending.
module mks_scanner
	import mks_pkg::*;
#(
	parameter int SETTLE_CYCLES = `MKS_SETTLE_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] row_in,
	output logic [7:0] row_out,
	output logic [7:0] row_oe,
	input wire logic [7:0] col_in,
	output logic [7:0] col_out,
	output logic [7:0] col_oe
);

	localparam logic [19:0] SETTLE_LAST = 20'(SETTLE_CYCLES - 1);
	localparam logic [19:0] PIN_LAST = `MKS_PIN_WAIT - 20'h00001;

	// Returns {found, index} of the lowest-numbered line pulled low.
	function automatic logic [3:0] first_low(input logic [7:0] lines);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (!lines[i]) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction : first_low

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [15:0] pin_s1, pin_s2, pin_s3, pin_stb, next_pin_stb;
	logic [7:0] col_stb, row_stb;

	// A line counts as changed only when stages two and three agree, which also drops single-cycle glitches.
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			next_pin_stb[i] = (pin_s2[i] == pin_s3[i]) ? pin_s3[i] : pin_stb[i];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1 <= 16'hffff;
			pin_s2 <= 16'hffff;
			pin_s3 <= 16'hffff;
			pin_stb <= 16'hffff;
		end else begin
			pin_s1 <= {row_in, col_in};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_stb <= next_pin_stb;
		end
	end

	assign col_stb = pin_stb[7:0];
	assign row_stb = pin_stb[15:8];

	// ----------------------------------------
	// Scan state machine and result
	// ----------------------------------------
	mks_state_t state, next_state;
	logic [19:0] cnt, next_cnt;
	logic [7:0] next_row_oe, next_col_oe;
	logic [7:0] col_ref, next_ref;
	logic [2:0] col_idx, next_col_idx, row_idx, next_row_idx;
	logic [5:0] res_code, next_code;
	logic [2:0] lock, next_lock;
	logic [3:0] shot, next_shot;
	logic [6:0] res_flags, next_flags;
	logic pend, next_pend, enable, next_enable;
	logic [3:0] col_hit, row_hit;
	logic [5:0] proc_code;
	logic [2:0] lock_hit;
	logic [3:0] shot_hit;
	logic is_alt, acc, wr_result, wr_ctrl;

	assign col_hit = first_low(col_stb);
	assign row_hit = first_low(row_stb);
	assign proc_code = {row_idx, col_idx};

	// Alternation key decoders, one comparator per key.
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_lock
			assign lock_hit[g] = (proc_code == `MKS_LOCK_BASE + 6'(g));
		end
		for (g = 0; g < 4; g++) begin : g_shot
			assign shot_hit[g] = (proc_code == `MKS_SHOT_BASE + 6'(g));
		end
	endgenerate
	assign is_alt = |{lock_hit, shot_hit};

	assign acc = psel && penable && pready;
	assign wr_result = acc && pwrite && (paddr == `MKS_OFF_RESULT);
	assign wr_ctrl = acc && pwrite && (paddr == `MKS_OFF_CTRL);

	// Next-state logic; the bus clear of pending comes first so a capture in the same cycle wins.
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_row_oe = row_oe;
		next_col_oe = col_oe;
		next_ref = col_ref;
		next_col_idx = col_idx;
		next_row_idx = row_idx;
		next_code = res_code;
		next_lock = lock;
		next_shot = shot;
		next_flags = res_flags;
		next_pend = pend;
		next_enable = enable;
		if (wr_result && pwdata[`MKS_RES_PEND_BIT]) begin
			next_pend = 1'b0;
		end
		if (wr_ctrl) begin
			next_enable = pwdata[`MKS_CTRL_EN_BIT];
		end
		unique case (state)
			ST_IDLE: begin
				// Any column change, press or release, starts a scan; a held key causes no further change.
				if (enable && (col_stb != col_ref)) begin
					next_state = ST_SETTLE;
					next_cnt = 20'h00000;
				end
			end
			ST_SETTLE: begin
				if (cnt == SETTLE_LAST) begin
					next_state = ST_COL_SAMP;
					next_cnt = 20'h00000;
				end else begin
					next_cnt = cnt + 20'h00001;
				end
			end
			ST_COL_SAMP: begin
				if (col_hit[3]) begin
					next_col_idx = col_hit[2:0];
					next_row_oe = 8'h00;
					next_col_oe = 8'hff;
					next_state = ST_ROW_WAIT;
				end else begin
					next_state = ST_RECOVER;
				end
			end
			ST_ROW_WAIT: begin
				if (cnt == PIN_LAST) begin
					next_state = ST_ROW_SAMP;
					next_cnt = 20'h00000;
				end else begin
					next_cnt = cnt + 20'h00001;
				end
			end
			ST_ROW_SAMP: begin
				next_row_oe = 8'hff;
				next_col_oe = 8'h00;
				if (row_hit[3]) begin
					next_row_idx = row_hit[2:0];
					next_state = ST_PROCESS;
				end else begin
					next_state = ST_RECOVER;
				end
			end
			ST_PROCESS: begin
				next_code = proc_code;
				next_lock = lock ^ lock_hit;
				next_flags = {lock ^ lock_hit, shot | shot_hit};
				next_shot = is_alt ? (shot | shot_hit) : 4'h0;
				next_pend = 1'b1;
				next_state = ST_RECOVER;
			end
			ST_RECOVER: begin
				// Let the rows-low picture reach the synchronisers before taking it as the new idle reference.
				if (cnt == PIN_LAST) begin
					next_ref = col_stb;
					next_state = ST_IDLE;
					next_cnt = 20'h00000;
				end else begin
					next_cnt = cnt + 20'h00001;
				end
			end
			default: begin
				// The eighth state code is unused; fall back to the idle wait with rows driven.
				next_state = ST_IDLE;
				next_row_oe = 8'hff;
				next_col_oe = 8'h00;
			end
		endcase
	end

	// Registers of the scan path; reset drives rows, senses columns and clears all results.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			cnt <= 20'h00000;
			row_oe <= 8'hff;
			col_oe <= 8'h00;
			row_out <= 8'h00;
			col_out <= 8'h00;
			col_ref <= `MKS_REF_RESET;
			col_idx <= 3'h0;
			row_idx <= 3'h0;
			res_code <= 6'h00;
			lock <= 3'h0;
			shot <= 4'h0;
			res_flags <= 7'h00;
			pend <= 1'b0;
			enable <= `MKS_CTRL_RESET;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			row_oe <= next_row_oe;
			col_oe <= next_col_oe;
			row_out <= 8'h00;
			col_out <= 8'h00;
			col_ref <= next_ref;
			col_idx <= next_col_idx;
			row_idx <= next_row_idx;
			res_code <= next_code;
			lock <= next_lock;
			shot <= next_shot;
			res_flags <= next_flags;
			pend <= next_pend;
			enable <= next_enable;
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;

	// Answer is registered in the setup cycle, so every access takes exactly one access cycle.
	always_comb begin
		next_pready = psel && !penable;
		next_pslverr = 1'b0;
		next_prdata = 32'h00000000;
		if (psel && !penable) begin
			unique case (paddr)
				`MKS_OFF_RESULT: next_prdata = {16'h0000, pend, res_flags, 2'h0, res_code};
				`MKS_OFF_CTRL: next_prdata = {31'h00000000, enable};
				`MKS_OFF_STATUS: next_prdata = {15'h0000, state != ST_IDLE, row_stb, col_stb};
				default: next_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_idle_rows_low: assert property (state == ST_IDLE |-> row_oe == 8'hff && col_oe == 8'h00)
		else $error("rows not driven low while idle");
	chk_swap_dirs: assert property (state == ST_ROW_SAMP |-> col_oe == 8'hff && row_oe == 8'h00)
		else $error("line directions not reversed for row sampling");
	chk_settle_wait: assert property (state == ST_SETTLE && next_state != ST_SETTLE |-> cnt == SETTLE_LAST)
		else $error("settling delay cut short");
	chk_code_position: assert property (state == ST_PROCESS |=> res_code == {$past(row_idx), $past(col_idx)})
		else $error("scancode does not match row and column");
	chk_release_no_code: assert property (state == ST_COL_SAMP && !col_hit[3] |=> state == ST_RECOVER ##1 $stable(res_code))
		else $error("release produced a scancode");
	chk_top_left_col: assert property (state == ST_COL_SAMP && col_hit[3] |=> col_idx == $past(col_hit[2:0]))
		else $error("column index is not the lowest low column");
	chk_oneshot_clear: assert property (state == ST_PROCESS && !is_alt |=> shot == 4'h0 && pend)
		else $error("one-shot flags not cleared after ordinary key");
	chk_lock_toggle: assert property (state == ST_PROCESS |=> lock == ($past(lock) ^ $past(lock_hit)))
		else $error("lock flag did not toggle");
	chk_back_to_idle: assert property (state == ST_PROCESS |=> state == ST_RECOVER ##[1:10] state == ST_IDLE)
		else $error("scanner did not return to idle");
	chk_pend_set_wins: assert property (state == ST_PROCESS && wr_result |=> pend)
		else $error("capture lost against pending clear");

	cov_key_press: cover property (state == ST_PROCESS && !is_alt);
	cov_alt_key: cover property (state == ST_PROCESS && is_alt);
	cov_release: cover property (state == ST_COL_SAMP && !col_hit[3]);
	cov_clear: cover property (wr_result && pend);

endmodule : mks_scanner
`default_nettype wire

/* tb/mks_keypad_model.sv */
// Passive 8 x 8 push-button matrix with a pull-up on every row and column line.
// Assumes the scanner only pulls lines low; the bench closes keys through the keys vector.
`timescale 1ns/100ps
`default_nettype none
module mks_keypad_model (
	input wire logic [63:0] keys,
	input wire logic [7:0] row_out,
	input wire logic [7:0] row_oe,
	input wire logic [7:0] col_out,
	input wire logic [7:0] col_oe,
	output logic [7:0] row_in,
	output logic [7:0] col_in
);
	// ----------------------------------------
	// Line resolution
	// ----------------------------------------
	// A closed key joins its row and column, and a line nobody pulls floats up to the pull-up level.
	// Only one hop is modelled, so ghost paths through three keys are not reproduced.
	always_comb begin
		row_in = ~(row_oe & ~row_out);
		col_in = ~(col_oe & ~col_out);
		for (int r = 0; r < 8; r++) begin
			for (int c = 0; c < 8; c++) begin
				if (keys[r*8+c] && row_oe[r] && !row_out[r]) col_in[c] = 1'b0;
				if (keys[r*8+c] && col_oe[c] && !col_out[c]) row_in[r] = 1'b0;
			end
		end
	end
endmodule : mks_keypad_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the keypad scanner: APB master, key stimulus and a result monitor.
// Assumes the scanner is built with a short settling count and a matrix model on its pins.
`timescale 1ns/100ps
`default_nettype none
`include "mks_regs.svh"
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, row_in, row_out, row_oe, col_in, col_out, col_oe;
	logic [31:0] pwdata, prdata, q;
	logic [63:0] keys;
	logic [2:0] lock;
	logic [3:0] shot;
	logic [64:0] nt;
	logic [64:0] notes[$];
	logic [5:0] seq[11] = '{6'h3d, 6'h09, 6'h3e, 6'h3f, 6'h3d, 6'h38, 6'h39, 6'h3a, 6'h3b, 6'h3c, 6'h12};
	int num_errors = 0;
	int checks_done = 0;

	mks_scanner #(.SETTLE_CYCLES(20)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.row_in(row_in), .row_out(row_out), .row_oe(row_oe), .col_in(col_in), .col_out(col_out), .col_oe(col_oe));
	mks_keypad_model pad (.keys(keys), .row_out(row_out), .row_oe(row_oe), .col_out(col_out), .col_oe(col_oe),
		.row_in(row_in), .col_in(col_in));

	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	task automatic fail_now(input string m);
		num_errors++;
		$display("wrong value at %0t: %s", $time, m);
	endtask : fail_now

	task automatic print_verdict();
		$display("mismatches %0d, comparisons %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	// ----------------------------------------
	// APB master and scan pacing
	// ----------------------------------------
	// Each transfer leaves a note {error, mask, value}; the request is held until ready is seen high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [31:0] e, input logic er);
		int n;
		notes.push_back({er, m, e});
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		if (pready !== 1'b1) begin
			fail_now("no ready");
			print_verdict();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Polls the busy flag, since the scan length depends on the synchroniser and settle count.
	task automatic wait_scan();
		int n;
		repeat (8) @(posedge pclk);
		n = 0;
		do begin
			apb(1'b0, `MKS_OFF_STATUS, 32'h0, 32'h0, 32'h0, 1'b0);
			n++;
		end while (q[`MKS_STATUS_BUSY_BIT] !== 1'b0 && n < 100);
		if (n >= 100) begin
			fail_now("scan hangs");
			print_verdict();
		end
	endtask : wait_scan

	// Presses keys k1 and k2 together, works out the expected word, then holds and releases.
	task automatic press(input logic [5:0] k1, input logic [5:0] k2, input logic [5:0] code);
		logic [31:0] e;
		keys <= keys | (64'h1 << k1) | (64'h1 << k2);
		if (code >= 6'h3d) lock[code-6'h3d] = ~lock[code-6'h3d];
		if (code >= 6'h38 && code <= 6'h3b) shot[code-6'h38] = 1'b1;
		e = {16'h0, 1'b1, lock, shot, 2'b00, code};
		if (code < 6'h38 || code == 6'h3c) shot = 4'h0;
		wait_scan();
		apb(1'b0, `MKS_OFF_RESULT, 32'h0, 32'hffffffff, e, 1'b0);
		apb(1'b1, `MKS_OFF_RESULT, 32'h8000, 32'h0, 32'h0, 1'b0);
		e[15] = 1'b0;
		wait_scan();
		apb(1'b0, `MKS_OFF_RESULT, 32'h0, 32'hffffffff, e, 1'b0);
		keys <= 64'h0;
		wait_scan();
		apb(1'b0, `MKS_OFF_RESULT, 32'h0, 32'hffffffff, e, 1'b0);
		checks_done++;
		if ({row_oe, col_oe, row_out, col_out} !== 32'hff000000) fail_now("lines not idle");
	endtask : press

	// ----------------------------------------
	// Monitor
	// ----------------------------------------
	// Takes the oldest note at every completed transfer and compares data and error.
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			checks_done++;
			if (notes.size() == 0) begin
				fail_now("unexpected transfer");
			end else begin
				nt = notes.pop_front();
				if (((prdata & nt[63:32]) !== nt[31:0]) || (pslverr !== nt[64])) fail_now("apb answer");
			end
		end
	end

	// ----------------------------------------
	// Clock and main sequence
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		keys = 64'h0;
		lock = 3'h0;
		shot = 4'h0;
		void'($urandom(32'h103c421c));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		checks_done++;
		if ({row_oe, col_oe, row_out, col_out} !== 32'hff000000) fail_now("reset lines");
		apb(1'b0, `MKS_OFF_RESULT, 32'h0, 32'hffffffff, 32'h0, 1'b0);
		apb(1'b0, `MKS_OFF_CTRL, 32'h0, 32'h1, 32'h1, 1'b0);
		apb(1'b0, 8'h40, 32'h0, 32'hffffffff, 32'h0, 1'b1);
		// Scanning switched off: a held key shows on the synced columns but starts no scan.
		apb(1'b1, `MKS_OFF_CTRL, 32'h0, 32'h0, 32'h0, 1'b0);
		keys <= 64'h1 << 6'h21;
		repeat (12) @(posedge pclk);
		apb(1'b0, `MKS_OFF_STATUS, 32'h0, 32'h1ffff, 32'h000000fd, 1'b0);
		apb(1'b0, `MKS_OFF_RESULT, 32'h0, 32'hffffffff, 32'h0, 1'b0);
		keys <= 64'h0;
		repeat (12) @(posedge pclk);
		apb(1'b1, `MKS_OFF_CTRL, 32'h1, 32'h0, 32'h0, 1'b0);
		apb(1'b0, `MKS_OFF_CTRL, 32'h0, 32'h1, 32'h1, 1'b0);
		for (int i = 0; i < 4; i++) begin
			q[5:0] = 6'($urandom % 56);
			press(q[5:0], q[5:0], q[5:0]);
		end
		press(6'd17, 6'd44, 6'd17);
		foreach (seq[i]) press(seq[i], seq[i], seq[i]);
		// A reset in mid-run must clear the lock flags and the result word.
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		lock = 3'h0;
		shot = 4'h0;
		repeat (4) @(posedge pclk);
		apb(1'b0, `MKS_OFF_RESULT, 32'h0, 32'hffffffff, 32'h0, 1'b0);
		press(6'h3e, 6'h3e, 6'h3e);
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
